// ==== src/connection_memory_block_init.sv ====
/*
 * Block-init engine of the connection memory: fill-value and
 * trigger/status registers on the host bus, power-up pass, bus fault on
 * memory access while a pass runs, and tri-state request for TDM outputs.
 * Assumes a synchronous host port: one request per cycle with chip select,
 * answered one cycle later; host_mem_in marks memory (not register) access.
 */
`timescale 1ns/10ps
// How it works
// - 32-bit read/write fill-value register at byte address 0x40288.
// - a pass writes the fill value into every connection memory word.
// - a full pass takes about 120 microseconds.
// - fill-value writes during a pass do not affect that pass.
// - reset clears fill value, then a pass zeroes the memory by itself.
// - 32-bit trigger/status register at byte address 0x4028c.
// - a start during a running pass is dropped; the pass completes.
// - reading trigger/status returns status, not the written word.
// - status bit 0 is one while a pass runs.
// - status bit 1 is one while the power-up pass runs.
// - status bits 31 to 2 read zero.
// - memory access during any pass is answered with a bus fault.
// - TDM outputs are tri-stated for the whole of any pass.
module connection_memory_block_init #(
    parameter int CM_DEPTH = cm_init_pkg::INIT_CYCLES,
    parameter int CM_AW    = $clog2(CM_DEPTH)
) (
    // clock and reset
    input  wire logic                           sys_clk_in,
    input  wire logic                           arst_n_in,
    // host bus
    input  wire logic                           host_cs_in,
    input  wire logic                           host_rd_in,
    input  wire logic                           host_wr_in,
    input  wire logic                           host_mem_in,
    input  wire logic [cm_init_pkg::ADDR_W-1:0] host_addr_in,
    input  wire logic [cm_init_pkg::DATA_W-1:0] host_wdata_in,
    output logic      [cm_init_pkg::DATA_W-1:0] host_rdata_out,
    output logic                                host_ack_out,
    output logic                                bus_fault_signal_out,
    // connection memory write port
    output logic                                cm_we_out,
    output logic      [CM_AW-1:0]               cm_addr_out,
    output logic      [cm_init_pkg::DATA_W-1:0] cm_wdata_out,
    // tdm output control
    output logic                                tdm_hiz_out
);
    import cm_init_pkg::*;

    cm_fill_if #(.AW(CM_AW)) fill ();

    logic [DATA_W-1:0] fill_value_q;
    logic [DATA_W-1:0] fill_value_d;
    logic              block_run_q;
    logic              block_run_d;
    logic              reset_init_q;
    logic              reset_init_d;
    logic              launch_q;
    logic              launch_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              ack_q;
    logic              ack_d;
    logic              fault_q;
    logic              fault_d;
    logic              hiz_q;
    logic              hiz_d;

    logic              reg_acc;
    logic              wr_fill;
    logic              wr_trig;
    logic              rd_fill;
    logic              rd_trig;
    logic              key_ok;
    logic              mem_acc;

    // ------------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------------
    always_comb
    begin
        reg_acc = host_cs_in && !host_mem_in;
        wr_fill = reg_acc && host_wr_in
                  && reg_hit(host_addr_in, FILL_VALUE_ADDR);
        wr_trig = reg_acc && host_wr_in
                  && reg_hit(host_addr_in, TRIGGER_STATUS_ADDR);
        rd_fill = reg_acc && host_rd_in
                  && reg_hit(host_addr_in, FILL_VALUE_ADDR);
        rd_trig = reg_acc && host_rd_in
                  && reg_hit(host_addr_in, TRIGGER_STATUS_ADDR);
        key_ok  = (host_wdata_in == FILL_KEY);
        mem_acc = host_cs_in && host_mem_in && (host_rd_in || host_wr_in);
    end

    // ------------------------------------------------------------------
    // registers and pass control
    // ------------------------------------------------------------------
    always_comb
    begin
        fill_value_d = fill_value_q;
        block_run_d  = block_run_q;
        reset_init_d = reset_init_q;
        launch_d     = 1'b0;
        rdata_d      = '0;
        ack_d        = reg_acc && (host_rd_in || host_wr_in);
        fault_d      = 1'b0;

        if (wr_fill)
        begin
            fill_value_d = host_wdata_in;
        end

        if (fill.done)
        begin
            block_run_d  = 1'b0;
            reset_init_d = 1'b0;
        end
        else if (wr_trig && key_ok && !block_run_q)
        begin
            // a key during a pass is simply dropped
            block_run_d = 1'b1;
            launch_d    = 1'b1;
        end
        // other words written to trigger/status leave everything as is

        if (rd_fill)
        begin
            rdata_d = fill_value_q;
        end
        else if (rd_trig)
        begin
            // read-back is status only, upper bits stay zero
            rdata_d[STAT_BLOCK_BIT] = block_run_q;
            rdata_d[STAT_RESET_BIT] = reset_init_q;
        end

        if (mem_acc && block_run_q)
        begin
            fault_d = 1'b1;
        end

        hiz_d = block_run_d;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            // power-up pass starts by itself with a zero word
            fill_value_q <= FILL_VALUE_RESET;
            block_run_q  <= 1'b1;
            reset_init_q <= 1'b1;
            launch_q     <= 1'b1;
            rdata_q      <= '0;
            ack_q        <= 1'b0;
            fault_q      <= 1'b0;
            hiz_q        <= 1'b1;
        end
        else
        begin
            fill_value_q <= fill_value_d;
            block_run_q  <= block_run_d;
            reset_init_q <= reset_init_d;
            launch_q     <= launch_d;
            rdata_q      <= rdata_d;
            ack_q        <= ack_d;
            fault_q      <= fault_d;
            hiz_q        <= hiz_d;
        end
    end

    assign fill.start = launch_q;
    assign fill.value = fill_value_q;

    // ------------------------------------------------------------------
    // fill writer
    // ------------------------------------------------------------------
    // one word per clock: depth equals the pass length in cycles
    cm_fill_writer #(
        .DEPTH (CM_DEPTH),
        .AW    (CM_AW)
    ) u_writer (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .fill       (fill.writer)
    );

    assign host_rdata_out       = rdata_q;
    assign host_ack_out         = ack_q;
    assign bus_fault_signal_out = fault_q;
    assign cm_we_out            = fill.we;
    assign cm_addr_out          = fill.addr;
    assign cm_wdata_out         = fill.data;
    assign tdm_hiz_out          = hiz_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    localparam int RUN_LIMIT = CM_DEPTH + 3;

    logic [31:0] run_cnt_q;
    logic        rd_trig_q;

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            run_cnt_q <= '0;
            rd_trig_q <= 1'b0;
        end
        else
        begin
            run_cnt_q <= block_run_q ? run_cnt_q + 32'd1 : 32'd0;
            rd_trig_q <= rd_trig;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_pass_length;
        run_cnt_q <= 32'(RUN_LIMIT);
    endproperty
    a_pass_length: assert property (p_pass_length)
        else $error("block init pass ran too long");

    property p_key_starts;
        wr_trig && key_ok && !block_run_q && !fill.done
            |=> block_run_q && launch_q ##1 fill.busy ##1 cm_we_out;
    endproperty
    a_key_starts: assert property (p_key_starts)
        else $error("key write did not start a pass");

    property p_busy_key_dropped;
        wr_trig && key_ok && block_run_q |=> !launch_q;
    endproperty
    a_busy_key_dropped: assert property (p_busy_key_dropped)
        else $error("start during a pass was not dropped");

    property p_other_word_ignored;
        wr_trig && !key_ok && !block_run_q |=> !block_run_q && !launch_q;
    endproperty
    a_other_word_ignored: assert property (p_other_word_ignored)
        else $error("non-key write started a pass");

    property p_status_bits;
        rd_trig |=> host_ack_out
            && host_rdata_out[STAT_BLOCK_BIT] == $past(block_run_q)
            && host_rdata_out[STAT_RESET_BIT] == $past(reset_init_q);
    endproperty
    a_status_bits: assert property (p_status_bits)
        else $error("status bits do not show pass state");

    property p_status_upper;
        host_ack_out && rd_trig_q |-> host_rdata_out[31:2] == 30'h0;
    endproperty
    a_status_upper: assert property (p_status_upper)
        else $error("status upper bits not zero");

    property p_mem_fault;
        mem_acc && block_run_q |=> bus_fault_signal_out;
    endproperty
    a_mem_fault: assert property (p_mem_fault)
        else $error("memory access during pass not faulted");

    property p_hiz_cover;
        cm_we_out |-> tdm_hiz_out && block_run_q;
    endproperty
    a_hiz_cover: assert property (p_hiz_cover)
        else $error("tdm outputs driven during a pass");

    property p_powerup_zero;
        reset_init_q && cm_we_out |-> cm_wdata_out == 32'h0000_0000;
    endproperty
    a_powerup_zero: assert property (p_powerup_zero)
        else $error("power-up pass wrote a nonzero word");

    property p_reset_init_ends;
        fill.done |=> !reset_init_q && !block_run_q && !tdm_hiz_out;
    endproperty
    a_reset_init_ends: assert property (p_reset_init_ends)
        else $error("status not cleared after pass end");

    property p_fault_cause;
        bus_fault_signal_out |-> $past(mem_acc) && $past(block_run_q);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("bus fault without a memory access in a pass");

    property p_fill_write;
        wr_fill |=> fill_value_q == $past(host_wdata_in);
    endproperty
    a_fill_write: assert property (p_fill_write)
        else $error("fill-value write not stored");

    property p_hiz_whole_pass;
        block_run_q |-> tdm_hiz_out;
    endproperty
    a_hiz_whole_pass: assert property (p_hiz_whole_pass)
        else $error("tdm outputs not tri-stated while a pass runs");

    c_host_pass: cover property (wr_trig && key_ok && !block_run_q);
    c_busy_key: cover property (wr_trig && key_ok && block_run_q);
    c_fault: cover property (mem_acc && block_run_q);
    c_pass_done: cover property (fill.done && !reset_init_q);

endmodule

// ==== src/cm_init_pkg.sv ====
/*
 * Shared constants for the connection memory block-init engine: host
 * register map, key word, status bit positions, timing and the state
 * type of the fill writer.
 * Assumes a 100 MHz system clock and byte addresses on the host bus.
 */
package cm_init_pkg;

    // ------------------------------------------------------------------
    // host register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W              = 19;
    localparam int          DATA_W              = 32;
    localparam logic [18:0] FILL_VALUE_ADDR     = 19'h40288;
    localparam logic [18:0] TRIGGER_STATUS_ADDR = 19'h4028c;
    localparam logic [31:0] FILL_KEY            = 32'h31415926;
    localparam logic [31:0] FILL_VALUE_RESET    = 32'h0000_0000;
    localparam int          STAT_BLOCK_BIT      = 0;
    localparam int          STAT_RESET_BIT      = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_TIME_US  = 120;
    localparam int INIT_CYCLES   = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // fill writer states
    // ------------------------------------------------------------------
    typedef enum logic {
        FILL_IDLE,
        FILL_RUN
    } fill_state_t;

    function automatic logic reg_hit(input logic [18:0] addr,
                                     input logic [18:0] offs);
        reg_hit = (addr == offs);
    endfunction

endpackage

// ==== src/cm_fill_if.sv ====
/*
 * Link between the block-init control and the fill writer: launch
 * request with its fill word, progress flags and the memory write port.
 * Assumes both ends share sys_clk_in.
 */
`timescale 1ns/10ps
interface cm_fill_if #(
    parameter int AW = 14
);
    logic                             start;
    logic [cm_init_pkg::DATA_W-1:0]   value;
    logic                             busy;
    logic                             done;
    logic                             we;
    logic [AW-1:0]                    addr;
    logic [cm_init_pkg::DATA_W-1:0]   data;

    modport writer (
        input  start,
        input  value,
        output busy,
        output done,
        output we,
        output addr,
        output data
    );

    modport ctrl (
        output start,
        output value,
        input  busy,
        input  done,
        input  we,
        input  addr,
        input  data
    );
endinterface

// ==== src/cm_fill_writer.sv ====
/*
 * Fill writer: on a start pulse latches the fill word and writes it to
 * every connection memory location, one word per clock, pulsing done with the last write.
 * Assumes start is only raised while the writer is idle.
 */
`timescale 1ns/10ps
module cm_fill_writer #(
    parameter int DEPTH = 12000,
    parameter int AW    = 14
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    // control side
    cm_fill_if.writer fill
);
    import cm_init_pkg::*;

    fill_state_t         state_q;
    fill_state_t         state_d;
    logic [AW-1:0]       cnt_q;
    logic [AW-1:0]       cnt_d;
    logic [DATA_W-1:0]   val_q;
    logic [DATA_W-1:0]   val_d;
    logic                we_q;
    logic                we_d;
    logic [AW-1:0]       addr_q;
    logic [AW-1:0]       addr_d;
    logic [DATA_W-1:0]   data_q;
    logic [DATA_W-1:0]   data_d;
    logic                done_q;
    logic                done_d;

    // ------------------------------------------------------------------
    // sweep
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        val_d   = val_q;
        we_d    = 1'b0;
        addr_d  = addr_q;
        data_d  = data_q;
        done_d  = 1'b0;
        case (state_q)
            FILL_IDLE:
            begin
                if (fill.start)
                begin
                    // word frozen here; later host writes wait a pass
                    state_d = FILL_RUN;
                    cnt_d   = '0;
                    val_d   = fill.value;
                end
            end
            FILL_RUN:
            begin
                we_d   = 1'b1;
                addr_d = cnt_q;
                data_d = val_q;
                if (cnt_q == AW'(DEPTH - 1))
                begin
                    state_d = FILL_IDLE;
                    done_d  = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q + AW'(1);
                end
            end
            default:
            begin
                state_d = FILL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q <= FILL_IDLE;
            cnt_q   <= '0;
            val_q   <= '0;
            we_q    <= 1'b0;
            addr_q  <= '0;
            data_q  <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            val_q   <= val_d;
            we_q    <= we_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            done_q  <= done_d;
        end
    end

    assign fill.busy = (state_q == FILL_RUN);
    assign fill.done = done_q;
    assign fill.we   = we_q;
    assign fill.addr = addr_q;
    assign fill.data = data_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_sweep_steps;
        we_q && $past(we_q) |-> addr_q == $past(addr_q) + AW'(1);
    endproperty
    a_sweep_steps: assert property (p_sweep_steps)
        else $error("fill address did not advance by one");

    property p_word_frozen;
        we_q && $past(we_q) |-> $stable(data_q);
    endproperty
    a_word_frozen: assert property (p_word_frozen)
        else $error("fill word changed inside a pass");

endmodule

// ==== test/host_model.sv ====
/*
 * Host processor model: one request at a time on the device's host port,
 * register or memory space, answer collected half a cycle after the take.
 * Assumes the device takes a request at the rising edge with select high.
 */
`timescale 1ns/10ps
module host_model
(
    // clock
    input  wire logic                           sys_clk_in,
    // answers from the device
    input  wire logic [cm_init_pkg::DATA_W-1:0] host_rdata_in,
    input  wire logic                           host_ack_in,
    input  wire logic                           bus_fault_signal_in,
    // request
    output logic                                host_cs_out,
    output logic                                host_rd_out,
    output logic                                host_wr_out,
    output logic                                host_mem_out,
    output logic      [cm_init_pkg::ADDR_W-1:0] host_addr_out,
    output logic      [cm_init_pkg::DATA_W-1:0] host_wdata_out
);
    import cm_init_pkg::*;

    initial
    begin
        host_cs_out    = 1'b0;
        host_rd_out    = 1'b0;
        host_wr_out    = 1'b0;
        host_mem_out   = 1'b0;
        host_addr_out  = 19'h00000;
        host_wdata_out = 32'h0000_0000;
    end

    // --------------------------------------------------------------
    // one transfer, driven and released on falling edges
    // --------------------------------------------------------------
    // released address and data lines show the inverse of the last value, never a stale copy
    task automatic req(input  logic              rd,
                       input  logic              wr,
                       input  logic              mem,
                       input  logic [ADDR_W-1:0] a,
                       input  logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q,
                       output logic              ack,
                       output logic              flt);
        @(negedge sys_clk_in);
        host_cs_out    = 1'b1;
        host_rd_out    = rd;
        host_wr_out    = wr;
        host_mem_out   = mem;
        host_addr_out  = a;
        host_wdata_out = d;
        @(negedge sys_clk_in);
        q              = host_rdata_in;
        ack            = host_ack_in;
        flt            = bus_fault_signal_in;
        host_cs_out    = 1'b0;
        host_rd_out    = 1'b0;
        host_wr_out    = 1'b0;
        host_mem_out   = 1'b0;
        host_addr_out  = ~a;
        host_wdata_out = ~d;
    endtask
endmodule

// ==== test/connection_memory_block_init_tb.sv ====
/*
 * Self-checking bench of the block-init engine: power-up pass, register
 * access, host passes, dropped keys and bus faults.
 * Assumes host_model drives the host port; memory depth shrunk to 16.
 */
`timescale 1ns/10ps
module connection_memory_block_init_tb;
    import cm_init_pkg::*;

    localparam int DEPTH = 16;
    localparam int AW    = 4;

    logic              sys_clk_in;
    logic              arst_n_in;
    logic              cs, rd, wr, mem_sel, ack_w, fault_w, we, hiz;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, cm_data;
    logic [AW-1:0]     cm_addr;
    logic [DATA_W-1:0] q;
    logic              ack, flt;
    logic [DATA_W-1:0] mem [DEPTH];
    int                wr_cnt, cyc, t0, dt, mismatches, n_tests;

    // --------------------------------------------------------------
    // clock, parts
    // --------------------------------------------------------------
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    host_model u_host (
        .sys_clk_in          (sys_clk_in),
        .host_rdata_in       (rdata),
        .host_ack_in         (ack_w),
        .bus_fault_signal_in (fault_w),
        .host_cs_out         (cs),
        .host_rd_out         (rd),
        .host_wr_out         (wr),
        .host_mem_out        (mem_sel),
        .host_addr_out       (addr),
        .host_wdata_out      (wdata)
    );

    connection_memory_block_init #(.CM_DEPTH(DEPTH), .CM_AW(AW)) dut (
        .sys_clk_in           (sys_clk_in),
        .arst_n_in            (arst_n_in),
        .host_cs_in           (cs),
        .host_rd_in           (rd),
        .host_wr_in           (wr),
        .host_mem_in          (mem_sel),
        .host_addr_in         (addr),
        .host_wdata_in        (wdata),
        .host_rdata_out       (rdata),
        .host_ack_out         (ack_w),
        .bus_fault_signal_out (fault_w),
        .cm_we_out            (we),
        .cm_addr_out          (cm_addr),
        .cm_wdata_out         (cm_data),
        .tdm_hiz_out          (hiz)
    );

    // --------------------------------------------------------------
    // connection memory image, address order watched on the fly
    // --------------------------------------------------------------
    // sampled mid-cycle, away from the edge that launches the write
    always @(negedge sys_clk_in)
    begin
        cyc++;
        if (we === 1'b1)
        begin
            mem[cm_addr] = cm_data;
            chk("cm write address", 32'(wr_cnt % DEPTH), 32'(cm_addr));
            wr_cnt++;
        end
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        u_host.req(1'b0, 1'b1, 1'b0, a, d, q, ack, flt);
        chk("write ack", 32'h1, {31'h0, ack});
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e, input string n);
        u_host.req(1'b1, 1'b0, 1'b0, a, 32'h0, q, ack, flt);
        chk("read ack", 32'h1, {31'h0, ack});
        chk(n, e, q);
    endtask

    // memory space access: no ack ever, fault only during a pass
    task automatic mem_acc(input logic e_flt);
        u_host.req(1'b1, 1'b0, 1'b1, 19'h00100, 32'h0, q, ack, flt);
        chk("memory ack", 32'h0, {31'h0, ack});
        chk("bus fault", {31'h0, e_flt}, {31'h0, flt});
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 100; i++)
        begin
            u_host.req(1'b1, 1'b0, 1'b0, TRIGGER_STATUS_ADDR, 32'h0,
                       q, ack, flt);
            if (q === 32'h0)
                break;
        end
        if (i == 100)
        begin
            mismatches++;
            $display("MISMATCH pass end expected 00000000 seen %h", q);
            report_and_stop();
        end
        repeat (3) @(negedge sys_clk_in);
    endtask

    task automatic chk_mem(input logic [31:0] v, input int n);
        for (int i = 0; i < DEPTH; i++)
            chk("cm word", v, mem[i]);
        chk("cm write count", 32'(n), 32'(wr_cnt));
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        arst_n_in  = 1'b0;
        mismatches = 0;
        n_tests    = 0;
        wr_cnt     = 0;
        cyc        = 0;
        repeat (5) @(negedge sys_clk_in);
        arst_n_in  = 1'b1;

        rd_reg(TRIGGER_STATUS_ADDR, 32'h3, "status start");
        chk("hiz power-up", 32'h1, {31'h0, hiz});
        rd_reg(FILL_VALUE_ADDR, 32'h0, "fill reset");
        mem_acc(1'b1);
        wait_idle();
        chk("hiz idle", 32'h0, {31'h0, hiz});
        chk_mem(32'h0, DEPTH);
        $display("test power_up done");

        wr_reg(FILL_VALUE_ADDR, 32'hc3a5_965a);
        rd_reg(FILL_VALUE_ADDR, 32'hc3a5_965a, "fill readback");
        wr_reg(TRIGGER_STATUS_ADDR, 32'h3141_5927);
        rd_reg(TRIGGER_STATUS_ADDR, 32'h0, "status after bad key");
        mem_acc(1'b0);
        rd_reg(19'h40290, 32'h0, "unmapped read");
        chk("no pass on bad key", 32'(DEPTH), 32'(wr_cnt));
        $display("test registers done");

        wr_reg(TRIGGER_STATUS_ADDR, FILL_KEY);
        rd_reg(TRIGGER_STATUS_ADDR, 32'h1, "status host pass");
        chk("hiz host pass", 32'h1, {31'h0, hiz});
        wr_reg(FILL_VALUE_ADDR, 32'h0f1e_2d3c);
        wr_reg(TRIGGER_STATUS_ADDR, FILL_KEY);
        mem_acc(1'b1);
        wait_idle();
        chk("hiz after pass", 32'h0, {31'h0, hiz});
        chk_mem(32'hc3a5_965a, 2 * DEPTH);
        rd_reg(FILL_VALUE_ADDR, 32'h0f1e_2d3c, "fill kept");
        $display("test host_pass done");

        wr_reg(TRIGGER_STATUS_ADDR, FILL_KEY);
        t0 = cyc;
        wait_idle();
        dt = cyc - t0;
        chk("pass len", 32'h1, 32'(dt >= DEPTH && dt <= DEPTH + 12));
        chk_mem(32'h0f1e_2d3c, 3 * DEPTH);
        $display("test second_pass done");

        // reset again while idle: fill word must clear and memory zero again
        arst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        rd_reg(FILL_VALUE_ADDR, 32'h0, "fill after reset");
        rd_reg(TRIGGER_STATUS_ADDR, 32'h3, "status reset");
        chk("hiz reset", 32'h1, {31'h0, hiz});
        wait_idle();
        chk_mem(32'h0, 4 * DEPTH);
        $display("test mid_reset done");

        report_and_stop();
    end
endmodule
